// [verilog/adsp_pkg.sv]
// Constants, types and layouts shared by the serial frame port design.
//
// Function
// R1: The output pin floats while chip select is high and until the MSB.
// R2: Every output word leaves MSB first, bit fifteen down to bit zero.
// R3: With frame sync high at select, MSB comes first, then falling edges.
// R4: With frame sync low at select, MSB waits for a low sync; rising edges.
// R5: Conversion and buffer reads send the 12-bit result then four zeros.
// R6: Config reads put the register in the last 12 bits; host skips 4.
// R7: The output floats again once the sixteenth bit has been presented.
// R8: The host may zero-fill unused trailing input bits after the command.
// R9: Results are straight binary, 000h at low and FFFh at high minus 1 LSB.
// R10: A result is a 10-bit capacitor stage plus a 2-bit resistor stage.
// R11: Bits resolve from the MSB down; above threshold gives 0 and drops it.
// R12: The input selector picks its input per command, break before make.
// R13: The host sends the command in bits 15..12 and data in bits 11..0.
// R14: The top four input bits are one of sixteen commands; write takes 12.
// R15: Inputs sample on rising edges without sync, falling edges with sync.
// R16: The whole output word is loaded at frame start for a stable frame.
`default_nettype none

package adsp_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned CMD_W      = 4;
  localparam int unsigned DATA_W     = 12;
  localparam int unsigned CAP_BITS   = 10;
  localparam int unsigned STR_BITS   = 2;
  localparam int unsigned CMD_MSB    = 15;
  localparam int unsigned CMD_LSB    = 12;
  localparam logic [4:0]  CMD_BITS   = 5'h04;
  localparam logic [4:0]  FULL_BITS  = 5'h10;
  localparam logic [3:0]  PAD_ZERO   = 4'h0;
  localparam logic [11:0] CODE_ZERO  = 12'h000;
  localparam logic [11:0] CFG_RST    = 12'h000;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_CH_LAST = 4'h7;
  localparam logic [3:0] CMD_PWDN    = 4'h8;
  localparam logic [3:0] CMD_CFG_RD  = 4'h9;
  localparam logic [3:0] CMD_CFG_WR  = 4'hA;
  localparam logic [3:0] CMD_TST_MID = 4'hB;
  localparam logic [3:0] CMD_TST_LO  = 4'hC;
  localparam logic [3:0] CMD_TST_HI  = 4'hD;
  localparam logic [3:0] CMD_BUF_RD  = 4'hE;

  // Selector codes: 0..7 external inputs, then the internal test inputs
  localparam logic [3:0] SEL_MID     = 4'h8;
  localparam logic [3:0] SEL_LO      = 4'h9;
  localparam logic [3:0] SEL_HI      = 4'hA;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SAMPLE_NS   = 500;
  localparam int unsigned SETTLE_NS   = 40;
  localparam int unsigned SAMPLE_CYC  = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  SAMPLE_CNT  = 8'(SAMPLE_CYC - 1);
  localparam logic [7:0]  SETTLE_CNT  = 8'(SETTLE_CYC - 1);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BREAK,
    ST_SAMPLE,
    ST_TRIAL,
    ST_DONE
  } adsp_state_e;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [11:0] data;
  } adsp_word_s;

  typedef struct packed {
    logic [3:0] sel;
    logic       en;
    logic       sample;
  } adsp_mux_s;

endpackage : adsp_pkg

`default_nettype wire

// [verilog/adsp_frame_port.sv]
// Serial frame port, result formatting and conversion sequencer.
`default_nettype none

module adsp_frame_port
  import adsp_pkg::*;
(
  // System clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Serial link pins
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        frame_sync_n_i,
  input  wire logic        serial_in_pin_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  // Analog front end
  input  wire logic        comp_above_i,
  output adsp_mux_s        mux_o,
  output logic [11:0]      trial_code_o,
  output logic             trial_string_o,
  // Status toward the rest of the chip
  output logic [11:0]      result_o,
  output logic             result_valid_o,
  output logic [11:0]      config_word_o,
  output logic             power_down_o
);

  // ----------------------------------------------------------------------
  // Link domain: frame capture
  // ----------------------------------------------------------------------
  logic              sync_on_r;
  logic [15:0]       snap_r;
  logic [15:0]       tx_word_r;

  // Mode and output word are caught on the select edge itself, so no
  // serial clock edge is needed before the MSB can be shown without sync
  always_ff @(negedge cs_n_i) begin
    sync_on_r <= ~frame_sync_n_i;
    snap_r    <= tx_word_r; // R16
  end

  // ----------------------------------------------------------------------
  // Link domain: no-sync path, rising in, falling out
  // ----------------------------------------------------------------------
  logic [4:0]  rcnt_p_r;
  logic [15:0] rsh_p_r;
  logic [4:0]  ocnt_n_r;
  logic [15:0] rword_p_r;
  logic        rtgl_p_r;
  logic [3:0]  cmd_p;

  assign cmd_p = {rsh_p_r[2:0], serial_in_pin_i};

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rcnt_p_r <= '0;
      rsh_p_r  <= '0;
    end else if (!sync_on_r && rcnt_p_r != FULL_BITS) begin
      rsh_p_r  <= {rsh_p_r[14:0], serial_in_pin_i}; // R15
      rcnt_p_r <= rcnt_p_r + 5'h01;
    end
  end

  // Short commands are handed over after four bits; zero padding that
  // follows is shifted in and dropped
  always_ff @(posedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rword_p_r <= '0;
      rtgl_p_r  <= 1'b0;
    end else if (!cs_n_i && !sync_on_r) begin
      if (rcnt_p_r == CMD_BITS - 5'h01 && cmd_p != CMD_CFG_WR) begin
        rword_p_r <= {cmd_p, CODE_ZERO}; // R14 R8
        rtgl_p_r  <= ~rtgl_p_r;
      end else if (rcnt_p_r == FULL_BITS - 5'h01 &&
                   rsh_p_r[14:11] == CMD_CFG_WR) begin
        rword_p_r <= {rsh_p_r[14:0], serial_in_pin_i}; // R14
        rtgl_p_r  <= ~rtgl_p_r;
      end
    end
  end

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      ocnt_n_r <= '0;
    end else if (!sync_on_r && ocnt_n_r != FULL_BITS) begin
      ocnt_n_r <= ocnt_n_r + 5'h01; // R3
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: sync path, falling in, rising out
  // ----------------------------------------------------------------------
  logic        go_r;
  logic [4:0]  rcnt_n_r;
  logic [15:0] rsh_n_r;
  logic [4:0]  ocnt_p_r;
  logic [15:0] rword_n_r;
  logic        rtgl_n_r;
  logic [3:0]  cmd_n;

  assign cmd_n = {rsh_n_r[2:0], serial_in_pin_i};

  // The falling edge that sees sync low also takes the first input bit
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      go_r     <= 1'b0;
      rcnt_n_r <= '0;
      rsh_n_r  <= '0;
    end else if (sync_on_r && !frame_sync_n_i) begin
      go_r     <= 1'b1;
      rcnt_n_r <= 5'h01; // R15
      rsh_n_r  <= {15'h0000, serial_in_pin_i};
    end else if (go_r && rcnt_n_r != FULL_BITS) begin
      rsh_n_r  <= {rsh_n_r[14:0], serial_in_pin_i}; // R15
      rcnt_n_r <= rcnt_n_r + 5'h01;
    end
  end

  always_ff @(negedge sclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rword_n_r <= '0;
      rtgl_n_r  <= 1'b0;
    end else if (!cs_n_i && sync_on_r && go_r && frame_sync_n_i) begin
      if (rcnt_n_r == CMD_BITS - 5'h01 && cmd_n != CMD_CFG_WR) begin
        rword_n_r <= {cmd_n, CODE_ZERO}; // R14 R8
        rtgl_n_r  <= ~rtgl_n_r;
      end else if (rcnt_n_r == FULL_BITS - 5'h01 &&
                   rsh_n_r[14:11] == CMD_CFG_WR) begin
        rword_n_r <= {rsh_n_r[14:0], serial_in_pin_i}; // R14
        rtgl_n_r  <= ~rtgl_n_r;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      ocnt_p_r <= '0;
    end else if (go_r && ocnt_p_r != FULL_BITS) begin
      ocnt_p_r <= ocnt_p_r + 5'h01; // R4
    end
  end

  // ----------------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------------
  logic [4:0] ocnt;
  logic       shown;

  assign ocnt  = sync_on_r ? ocnt_p_r : ocnt_n_r;
  assign shown = sync_on_r ? go_r : 1'b1; // R4
  // Select gates the enable directly so the pin floats with no clock
  assign serial_out_pin_oe_o = !cs_n_i && shown &&
                               ocnt != FULL_BITS; // R1 R7
  assign serial_out_pin_o    = snap_r[~ocnt[3:0]]; // R2

  // ----------------------------------------------------------------------
  // System domain: crossings
  // ----------------------------------------------------------------------
  logic [1:0] cs_sync_r;
  logic [2:0] tgl_p_sync_r;
  logic [2:0] tgl_n_sync_r;
  logic [1:0] comp_sync_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cs_sync_r    <= 2'h3;
      tgl_p_sync_r <= '0;
      tgl_n_sync_r <= '0;
      comp_sync_r  <= '0;
    end else begin
      cs_sync_r    <= {cs_sync_r[0], cs_n_i};
      tgl_p_sync_r <= {tgl_p_sync_r[1:0], rtgl_p_r};
      tgl_n_sync_r <= {tgl_n_sync_r[1:0], rtgl_n_r};
      comp_sync_r  <= {comp_sync_r[0], comp_above_i};
    end
  end

  logic       rx_p_evt;
  logic       rx_n_evt;
  logic       rx_evt;
  adsp_word_s rx_word;

  // Captured words hold still for many link cycles after their toggle
  assign rx_p_evt = tgl_p_sync_r[2] ^ tgl_p_sync_r[1];
  assign rx_n_evt = tgl_n_sync_r[2] ^ tgl_n_sync_r[1];
  assign rx_evt   = rx_p_evt | rx_n_evt;
  assign rx_word  = rx_n_evt ? rword_n_r : rword_p_r; // R13

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  function automatic logic is_select(input logic [3:0] c);
    is_select = c <= CMD_CH_LAST || c == CMD_TST_MID ||
                c == CMD_TST_LO || c == CMD_TST_HI;
  endfunction : is_select

  function automatic logic [3:0] sel_code(input logic [3:0] c);
    case (c)
      CMD_TST_MID: sel_code = SEL_MID;
      CMD_TST_LO:  sel_code = SEL_LO;
      CMD_TST_HI:  sel_code = SEL_HI;
      default:     sel_code = c;
    endcase
  endfunction : sel_code

  logic [11:0] cfg_r;
  logic        cfg_view_r;
  logic        pwdn_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_r <= CFG_RST;
    end else if (rx_evt && rx_word.cmd == CMD_CFG_WR) begin
      cfg_r <= rx_word.data; // R14
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cfg_view_r <= 1'b0;
      pwdn_r     <= 1'b0;
    end else if (rx_evt) begin
      cfg_view_r <= rx_word.cmd == CMD_CFG_RD; // R14
      pwdn_r     <= rx_word.cmd == CMD_PWDN;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  adsp_state_e state_r;
  logic [7:0]  wait_r;
  logic [3:0]  bit_r;
  logic [11:0] code_r;
  logic [11:0] result_r;
  logic        valid_r;
  logic [3:0]  sel_r;
  logic [3:0]  next_sel_r;
  logic        start;

  assign start = rx_evt && is_select(rx_word.cmd);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r    <= ST_IDLE;
      wait_r     <= '0;
      bit_r      <= '0;
      next_sel_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            next_sel_r <= sel_code(rx_word.cmd); // R12
            state_r    <= ST_BREAK;
          end
        end
        // One cycle with every input open before the new one closes
        ST_BREAK: begin
          wait_r  <= SAMPLE_CNT;
          state_r <= ST_SAMPLE; // R12
        end
        ST_SAMPLE: begin
          if (wait_r == 8'h00) begin
            bit_r   <= 4'(DATA_W - 1);
            wait_r  <= SETTLE_CNT;
            state_r <= ST_TRIAL;
          end else begin
            wait_r <= wait_r - 8'h01;
          end
        end
        ST_TRIAL: begin
          if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
          end else if (bit_r == 4'h0) begin
            state_r <= ST_DONE;
          end else begin
            bit_r  <= bit_r - 4'h1; // R11
            wait_r <= SETTLE_CNT;
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sel_r <= '0;
    end else if (state_r == ST_BREAK) begin
      sel_r <= next_sel_r; // R12
    end
  end

  // Trial weight on top of the bits already kept; the comparator is
  // read only after the settle time so the sync delay is covered
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      code_r <= CODE_ZERO;
    end else if (state_r == ST_SAMPLE) begin
      code_r <= CODE_ZERO;
    end else if (state_r == ST_TRIAL && wait_r == 8'h00) begin
      code_r[bit_r] <= ~comp_sync_r[1]; // R11
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      result_r <= CODE_ZERO;
      valid_r  <= 1'b0;
    end else begin
      valid_r <= state_r == ST_DONE;
      if (state_r == ST_DONE) begin
        result_r <= code_r; // R9
      end
    end
  end

  logic [11:0] trial_r;
  logic        string_r;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      trial_r  <= CODE_ZERO;
      string_r <= 1'b0;
    end else begin
      trial_r  <= (state_r == ST_TRIAL) ?
                  (code_r | (12'h001 << bit_r)) : CODE_ZERO; // R11
      string_r <= state_r == ST_TRIAL &&
                  bit_r < 4'(STR_BITS); // R10
    end
  end

  // ----------------------------------------------------------------------
  // Output word, refreshed only between frames
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_word_r <= '0;
    end else if (cs_sync_r[1]) begin
      tx_word_r <= cfg_view_r ? {PAD_ZERO, cfg_r}      // R6
                              : {result_r, PAD_ZERO}; // R5
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mux_o <= '0;
    end else begin
      mux_o.sel    <= (state_r == ST_BREAK) ? next_sel_r : sel_r; // R12
      mux_o.en     <= state_r == ST_SAMPLE || state_r == ST_TRIAL;
      mux_o.sample <= state_r == ST_SAMPLE;
    end
  end

  assign trial_code_o   = trial_r;
  assign trial_string_o = string_r;
  assign result_o       = result_r;
  assign result_valid_o = valid_r;
  assign config_word_o  = cfg_r;
  assign power_down_o   = pwdn_r;

endmodule : adsp_frame_port

`default_nettype wire

// [dv/adsp_sva.sv]
// Pin-level assertions for the serial frame port.
`default_nettype none
module adsp_sva
  import adsp_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  // Link
  input wire logic        sclk_i,
  input wire logic        cs_n_i,
  input wire logic        frame_sync_n_i,
  input wire logic        serial_out_pin_oe_o,
  // Converter
  input wire adsp_mux_s   mux_o,
  input wire logic [11:0] trial_code_o,
  input wire logic        trial_string_o,
  input wire logic [11:0] result_o,
  input wire logic        result_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] fall_cnt_r;
  logic       no_sync_r;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // -----
  // Link helpers
  // -----
  // Saturates so a long clock burst cannot wrap back into range
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) fall_cnt_r <= 5'h00;
    else if (fall_cnt_r != 5'h1F) fall_cnt_r <= fall_cnt_r + 5'h01;
  end
  always_ff @(negedge cs_n_i) begin
    no_sync_r <= frame_sync_n_i;
  end
  property p_idle; cs_n_i |-> !serial_out_pin_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("driven while idle");
  property p_lead;
    $fell(cs_n_i) && frame_sync_n_i |-> serial_out_pin_oe_o;
  endproperty
  a_lead: assert property (p_lead) else $error("msb not driven");
  property p_wait;
    $fell(cs_n_i) && !frame_sync_n_i && fall_cnt_r == 5'h00
      |-> !serial_out_pin_oe_o;
  endproperty
  a_wait: assert property (p_wait) else $error("driven before sync");
  property p_len;
    !cs_n_i && no_sync_r && $stable(fall_cnt_r)
      |-> serial_out_pin_oe_o == (fall_cnt_r < 5'h10);
  endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_first;
    $past(trial_code_o) == 12'h000 && trial_code_o != 12'h000
      |-> trial_code_o == 12'h800;
  endproperty
  a_first: assert property (p_first) else $error("first weight");
  property p_str;
    trial_code_o != 12'h000
      |-> trial_string_o == (trial_code_o[1:0] != 2'h0);
  endproperty
  a_str: assert property (p_str) else $error("stage split");
  property p_bbm; !$stable(mux_o.sel) |-> !mux_o.en; endproperty
  a_bbm: assert property (p_bbm) else $error("make before break");
  property p_make; $rose(mux_o.en) |-> $stable(mux_o.sel); endproperty
  a_make: assert property (p_make) else $error("select on make");
  property p_res; !$stable(result_o) |-> result_valid_o; endproperty
  a_res: assert property (p_res) else $error("silent update");
  property p_done; $fell(mux_o.sample) |-> ##[12:80] result_valid_o;
  endproperty
  a_done: assert property (p_done) else $error("no result");
  c_sync: cover property ($fell(cs_n_i) && !frame_sync_n_i);
  c_res: cover property (result_valid_o);
  c_str: cover property (trial_string_o);
endmodule : adsp_sva
`default_nettype wire

// [dv/adsp_host.sv]
// Host serial port model that runs frames on the link.
`default_nettype none
module adsp_host (
  // Link pins
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        sync_n_o,
  output logic        din_o,
  input  wire logic   dout_i,
  // Captured line; bits 17 and 16 are taken while it floats
  output logic [17:0] rx_o,
  output logic        done_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // A short select pulse at start gives the link counters a real clear
  initial begin
    {sclk_o, din_o, done_o, cs_n_o} = 4'h0;
    sync_n_o = 1'b1;
    #1 cs_n_o = 1'b1;
  end
  // Sync mode spends one extra pulse loading the first bit
  task automatic frame(input logic sync, input logic [15:0] w);
    #3 sync_n_o = !sync;
    #15 rx_o[17] = dout_i;
    cs_n_o = 1'b0;
    din_o = w[15];
    #15 if (sync) begin
      rx_o[17] = dout_i;
      sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
      #15 sync_n_o = 1'b1;
    end
    for (int i = 15; i >= 0; i--) begin
      rx_o[i] = dout_i;
      if (sync && i > 0) din_o = w[i-1];
      sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
      if (!sync && i > 0) din_o = w[i-1];
      #15;
    end
    rx_o[16] = dout_i;
    cs_n_o = 1'b1;
    din_o = !din_o;
    done_o = 1'b1;
    #1 done_o = 1'b0;
  endtask : frame
endmodule : adsp_host
`default_nettype wire

// [dv/adsp_frame_port_tb.sv]
// Self-checking bench for the serial frame port.
`default_nettype none
module adsp_frame_port_tb
  import adsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, sclk, cs_n, sync_n, din, dout, oe, comp;
  logic        tstr, rv, pd, dn;
  logic [11:0] trial, res, cfg, tgt, cfg_e, last;
  logic [17:0] rx;
  logic [3:0]  prev;
  adsp_mux_s   mux;
  wire         line = oe ? dout : 1'bz;
  int          n_fail, check_count, seed, k, n;
  logic [18:0] q_w[$];
  logic [15:0] q_r[$];
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  adsp_frame_port u_dut (
    .sys_clk_i(clk), .sys_rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n),
    .frame_sync_n_i(sync_n), .serial_in_pin_i(din),
    .serial_out_pin_o(dout), .serial_out_pin_oe_o(oe),
    .comp_above_i(comp), .mux_o(mux), .trial_code_o(trial),
    .trial_string_o(tstr), .result_o(res), .result_valid_o(rv),
    .config_word_o(cfg), .power_down_o(pd)
  );
  adsp_host u_host (
    .sclk_o(sclk), .cs_n_o(cs_n), .sync_n_o(sync_n), .din_o(din),
    .dout_i(line), .rx_o(rx), .done_o(dn)
  );
  // Input level held as a code: node is above trip when the trial exceeds it
  always @(negedge clk) comp <= trial > tgt;
  // -----
  // Checking
  // -----
  task automatic fail(input string m);
    n_fail++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask : fail
  task automatic chk_v(input logic [15:0] g, e, input string m);
    check_count++;
    if (g !== e) fail(m);
  endtask : chk_v
  // Config reads skip the top four bits, which the port drives as zeros
  task automatic chk_w(input logic [17:0] g, input logic [18:0] e);
    check_count++;
    if (e[18] ? ({g[17:16], g[11:0]} !== {e[17:16], e[11:0]})
              : (g !== e[17:0])) fail("frame word");
  endtask : chk_w
  always @(posedge dn) begin
    if (q_w.size() == 0) fail("extra frame");
    else chk_w(rx, q_w.pop_front());
  end
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      if (q_r.size() == 0) fail("extra result");
      else chk_v({mux.sel, res}, q_r.pop_front(), "result");
    end
  end
  task automatic send(input logic s, input logic [15:0] w);
    q_w.push_back(prev == CMD_CFG_RD ? {1'b1, 2'bzz, 4'h0, cfg_e}
                                     : {1'b0, 2'bzz, last, 4'h0});
    u_host.frame(s, w);
    prev = w[15:12];
    repeat (6) @(negedge clk);
  endtask : send
  task automatic conv(input logic s, input logic [3:0] c,
                      input logic [11:0] v);
    tgt = v;
    q_r.push_back({c < 4'h8 ? c : c - 4'h3, v});
    send(s, {c, 12'h000});
    for (n = 0; n < 300 && q_r.size() > 0; n++) @(negedge clk);
    if (q_r.size() > 0) fail("no result");
    last = v;
  endtask : conv
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    seed = 32'h19BF1C77;
    rst = 1'b1;
    tgt = 12'h000;
    last = 12'h000;
    cfg_e = 12'h000;
    prev = 4'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    send(1'b0, {CMD_PWDN, 12'h000});
    chk_v({15'h0, pd}, 16'h0001, "power down");
    $display("test power down done");
    for (k = 0; k < 11; k++) begin
      conv(k[0], k < 8 ? k[3:0] : k[3:0] + 4'h3, k == 0 ? 12'h000 :
           k == 1 ? 12'hFFF : 12'($random(seed)));
    end
    chk_v({15'h0, pd}, 16'h0000, "power up");
    $display("test conversions done");
    send(1'b1, {CMD_BUF_RD, 12'h000});
    cfg_e = 12'($random(seed));
    send(1'b0, {CMD_CFG_WR, cfg_e});
    chk_v({4'h0, cfg}, {4'h0, cfg_e}, "config");
    send(1'b1, {CMD_CFG_RD, 12'h000});
    send(1'b0, 16'hF000);
    send(1'b1, 16'hE000);
    $display("test config done");
    complete_run();
  end
  initial begin
    #200000;
    fail("timeout");
    complete_run();
  end
endmodule : adsp_frame_port_tb
bind adsp_frame_port adsp_sva u_sva (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .frame_sync_n_i(frame_sync_n_i),
  .serial_out_pin_oe_o(serial_out_pin_oe_o), .mux_o(mux_o),
  .trial_code_o(trial_code_o), .trial_string_o(trial_string_o),
  .result_o(result_o), .result_valid_o(result_valid_o)
);
`default_nettype wire
